// ### uvp_sys_regs.sv
// Purpose: System setup and regulator function select registers with the logic they steer.
// Assumes: Host accesses arrive decoded as address, write strobe and read strobe on clk.
// Notes:   Pins from outside the domain pass two flip-flops before use.
// Functional notes
// - Bits 15:12 of system setup set the digital undervoltage threshold at 32 mV per step.
// - Digital undervoltage detection works only while bit 11 is one.
// - With bit 10 set, analog undervoltage detection is blocked while the overcurrent flag is high.
// - Bit 9 set disables analog undervoltage protection; clear enables it.
// - Digital undervoltage trips only when the filtered overcurrent flag and the low voltage coincide.
// - The overcurrent filter lasts 800, 1000 or 1200 ns by code; code 11 forces the flag high.
// - Bit 6 set starts the AC droop loop at soft start; clear starts it after power-on setup.
// - Bit 5 of system setup ignores writes and reads zero.
// - Bit 4 set halves per-phase current resolution, doubling range.
// - Bit 3 set halves total current resolution for telemetry, protection and shedding levels.
// - Bits 2:0 store the sense-gain indicator code for host tools.
// - Bit 14 of function select chooses hiccup when zero and latch-off when one on thermal fault.
// - In the middle power state with bit 13 set, shedding waits for the voltage-ID pin to leave high-Z.
// - Bit 12 picks phase count from a register or grounded sense pins sampled only at power-on setup.
module uvp_sys_regs
   import uvp_pkg::*;
#(
   parameter int PHASES = 6
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [15:0]       reg_wdata,
   output logic      [15:0]       reg_rdata,
   output logic                   reg_rvalid,
   output logic                   reg_err,
   input  wire logic [3:0]        vout_mv_code,
   input  wire logic              analog_uv_raw,
   input  wire logic              oc_raw,
   input  wire logic              por_done,
   input  wire logic              soft_start_begin,
   input  wire logic              soft_start_done,
   input  wire logic              power_state_middle,
   input  wire logic              vid_high_z_pin,
   input  wire logic [PHASES-1:0] cs_grounded_pin,
   input  wire logic [3:0]        reg_phase_count,
   input  wire logic              thermal_fault,
   output logic [9:0]             digital_undervolt_threshold_mv,
   output logic                   output_undervolt_protection,
   output logic                   analog_uv_trip,
   output logic                   ac_droop_active,
   output logic                   phase_half_res,
   output logic                   total_half_res,
   output logic [2:0]             sense_gain_indicator,
   output logic                   thermal_latch_mode,
   output logic                   thermal_shutdown,
   output logic                   automatic_phase_shedding,
   output logic [3:0]             active_phase_count
);
   logic [15:0] sys_ff;
   logic [15:0] func_ff;
   logic        hit_sys;
   logic        hit_func;
   logic        oc_filt;
   logic        dig_uv;
   logic [1:0]  vid_sync_ff;
   logic [1:0]  cs_sync_ff [PHASES];
   logic [PHASES-1:0] cs_s;
   logic [3:0]  pin_count;
   logic [3:0]  pin_count_ff;
   logic        por_seen_ff;
   logic        vid_seen_ff;
   logic        ac_ff;
   logic        tlatch_ff;
   logic [15:0] nxt_rdata;
   uvp_shed_t   shed_ff;
   uvp_shed_t   nxt_shed;

   // Address decode.
   assign hit_sys  = (reg_addr == UVP_OFS_SYS_SETUP);
   assign hit_func = (reg_addr == UVP_OFS_REG_FUNC);

   // Writes keep reserved bits at zero through the write masks.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_ff  <= UVP_RST_SYS_SETUP;
         func_ff <= UVP_RST_REG_FUNC;
      end else begin
         if (reg_wr && hit_sys)
            sys_ff <= reg_wdata & UVP_WMASK_SYS_SETUP;
         if (reg_wr && hit_func)
            func_ff <= reg_wdata & UVP_WMASK_REG_FUNC;
      end
   end

   // Read data; unmapped addresses read zero and flag an error.
   assign nxt_rdata = hit_sys  ? (sys_ff & UVP_WMASK_SYS_SETUP) :
                      hit_func ? (func_ff & UVP_WMASK_REG_FUNC) : 16'h0000;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
         reg_err    <= 1'b0;
      end else begin
         reg_rdata  <= reg_rd ? nxt_rdata : reg_rdata;
         reg_rvalid <= reg_rd;
         reg_err    <= (reg_rd || reg_wr) && !hit_sys && !hit_func;
      end
   end

   // Overcurrent deglitch filter.
   uvp_oc_filter u_filt (
      .clk         (clk),
      .rst         (rst),
      .oc_raw      (oc_raw),
      .time_sel    (sys_ff[UVP_FILT_HI:UVP_FILT_LO]),
      .oc_filtered (oc_filt)
   );

   // Threshold in millivolts, and the digital detector gated by its enable.
   assign digital_undervolt_threshold_mv =
      10'(sys_ff[UVP_THR_HI:UVP_THR_LO] * UVP_THR_MV_PER_LSB);
   assign dig_uv = (vout_mv_code < sys_ff[UVP_THR_HI:UVP_THR_LO]);
   assign output_undervolt_protection =
      sys_ff[UVP_DIG_EN_BIT] && dig_uv && oc_filt;
   // Analog path: the disable bit wins, then optional masking by overcurrent.
   assign analog_uv_trip = analog_uv_raw && !sys_ff[UVP_ANA_DIS_BIT]
                           && !(sys_ff[UVP_OC_MASK_BIT] && oc_raw);

   // Plain configuration outputs.
   assign phase_half_res       = sys_ff[UVP_PH_RES_BIT];
   assign total_half_res       = sys_ff[UVP_TOT_RES_BIT];
   assign sense_gain_indicator = sys_ff[UVP_GAIN_HI:UVP_GAIN_LO];
   assign thermal_latch_mode   = func_ff[UVP_TEMP_LATCH_BIT];

   // Pin synchronisers; only the second stage is read.
   // The voltage-ID stages reset to the high-Z level, so leaving reset never fakes a first exit.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         vid_sync_ff <= 2'h3;
      else
         vid_sync_ff <= {vid_sync_ff[0], vid_high_z_pin};
   end
   genvar gi;
   generate
      for (gi = 0; gi < PHASES; gi++) begin : g_cs
         always_ff @(posedge clk or posedge rst) begin
            if (rst)
               cs_sync_ff[gi] <= 2'h0;
            else
               cs_sync_ff[gi] <= {cs_sync_ff[gi][0], cs_grounded_pin[gi]};
         end
         assign cs_s[gi] = cs_sync_ff[gi][1];
      end
   endgenerate

   // Count phases up to the first grounded sense pin.
   always_comb begin
      pin_count = 4'(PHASES);
      for (int i = PHASES - 1; i >= 0; i--) begin
         if (cs_s[i])
            pin_count = 4'(i);
      end
   end

   // Pin count is caught once, at power-on setup completion; later pin changes are ignored.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_count_ff <= 4'h0;
         por_seen_ff  <= 1'b0;
      end else if (por_done && !por_seen_ff) begin
         pin_count_ff <= pin_count;
         por_seen_ff  <= 1'b1;
      end
   end
   assign active_phase_count = func_ff[UVP_PH_SRC_BIT] ? pin_count_ff : reg_phase_count;

   // AC droop start, held once started.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         ac_ff <= 1'b0;
      else if (sys_ff[UVP_AC_START_BIT] ? soft_start_begin : por_done)
         ac_ff <= 1'b1;
   end
   assign ac_droop_active = ac_ff;

   // Thermal response: latch holds until reset, hiccup follows the fault.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         tlatch_ff <= 1'b0;
      else if (thermal_fault && func_ff[UVP_TEMP_LATCH_BIT])
         tlatch_ff <= 1'b1;
   end
   assign thermal_shutdown = tlatch_ff || thermal_fault;

   // Record the first exit of the voltage-ID pin from high impedance.
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         vid_seen_ff <= 1'b0;
      else if (!vid_sync_ff[1])
         vid_seen_ff <= 1'b1;
   end

   // Shedding start sequencer.
   always_comb begin
      nxt_shed = shed_ff;
      unique case (shed_ff)
         UVP_SH_IDLE:
            if (soft_start_done)
               nxt_shed = (power_state_middle && func_ff[UVP_SHED_WAIT_BIT] && !vid_seen_ff)
                          ? UVP_SH_WAIT_VID : UVP_SH_ACTIVE;
         UVP_SH_WAIT_VID:
            if (vid_seen_ff)
               nxt_shed = UVP_SH_ACTIVE;
         UVP_SH_ACTIVE:
            nxt_shed = UVP_SH_ACTIVE;
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         shed_ff <= UVP_SH_IDLE;
      else
         shed_ff <= nxt_shed;
   end
   assign automatic_phase_shedding = (shed_ff == UVP_SH_ACTIVE);

   chk_reserved_bit_zero: assert property (@(posedge clk) disable iff (rst)
      reg_rvalid && $past(hit_sys) |-> reg_rdata[5] == 1'b0)
      else $error("reserved bit 5 read nonzero");
   chk_func_top_zero: assert property (@(posedge clk) disable iff (rst)
      reg_rvalid && $past(hit_func) |-> reg_rdata[15] == 1'b0)
      else $error("bit 15 read nonzero");
   chk_digital_uv_gate: assert property (@(posedge clk) disable iff (rst)
      output_undervolt_protection |-> sys_ff[UVP_DIG_EN_BIT] && oc_filt && dig_uv)
      else $error("digital trip without cause");
   chk_dig_uv_and: assert property (@(posedge clk) disable iff (rst)
      sys_ff[UVP_DIG_EN_BIT] && dig_uv && oc_filt |-> output_undervolt_protection)
      else $error("digital trip missed");
   chk_analog_disable: assert property (@(posedge clk) disable iff (rst)
      sys_ff[UVP_ANA_DIS_BIT] |-> !analog_uv_trip)
      else $error("analog trip while disabled");
   chk_analog_mask: assert property (@(posedge clk) disable iff (rst)
      sys_ff[UVP_OC_MASK_BIT] && oc_raw |-> !analog_uv_trip)
      else $error("analog trip while masked");
   chk_threshold_scale: assert property (@(posedge clk) disable iff (rst)
      digital_undervolt_threshold_mv == 10'(sys_ff[UVP_THR_HI:UVP_THR_LO]) * 10'd32)
      else $error("threshold scale wrong");
   chk_shed_wait_vid: assert property (@(posedge clk) disable iff (rst)
      shed_ff == UVP_SH_WAIT_VID && !vid_seen_ff |=> !automatic_phase_shedding)
      else $error("shedding started before vid");
   chk_thermal_latch: assert property (@(posedge clk) disable iff (rst)
      thermal_fault && func_ff[UVP_TEMP_LATCH_BIT] |=> thermal_shutdown [*3])
      else $error("latch did not hold");
   cov_dig_trip: cover property (@(posedge clk) disable iff (rst) output_undervolt_protection);
   cov_shed_wait: cover property (@(posedge clk) disable iff (rst)
      shed_ff == UVP_SH_WAIT_VID ##1 shed_ff == UVP_SH_ACTIVE);
   cov_ac_start: cover property (@(posedge clk) disable iff (rst) $rose(ac_droop_active));
endmodule // uvp_sys_regs

// ### uvp_pkg.sv
// Purpose: Shared constants for the undervoltage protection and system setup register bank.
// Assumes: 16-bit registers reached over a simple decoded write/read command port.
// Notes:   Field positions, offsets, reset values and timing counts live here only.
package uvp_pkg;
   localparam logic [7:0]  UVP_OFS_SYS_SETUP   = 8'h44;
   localparam logic [7:0]  UVP_OFS_REG_FUNC    = 8'h45;
   localparam logic [15:0] UVP_RST_SYS_SETUP   = 16'h0000;
   localparam logic [15:0] UVP_RST_REG_FUNC    = 16'h0000;
   // Writable bit masks; bit 5 of system setup and bit 15 of function select read zero.
   localparam logic [15:0] UVP_WMASK_SYS_SETUP = 16'hffdf;
   localparam logic [15:0] UVP_WMASK_REG_FUNC  = 16'h7fff;
   // System setup field positions.
   localparam int UVP_THR_HI       = 15;
   localparam int UVP_THR_LO       = 12;
   localparam int UVP_DIG_EN_BIT   = 11;
   localparam int UVP_OC_MASK_BIT  = 10;
   localparam int UVP_ANA_DIS_BIT  = 9;
   localparam int UVP_FILT_HI      = 8;
   localparam int UVP_FILT_LO      = 7;
   localparam int UVP_AC_START_BIT = 6;
   localparam int UVP_PH_RES_BIT   = 4;
   localparam int UVP_TOT_RES_BIT  = 3;
   localparam int UVP_GAIN_HI      = 2;
   localparam int UVP_GAIN_LO      = 0;
   // Function select field positions.
   localparam int UVP_TEMP_LATCH_BIT = 14;
   localparam int UVP_SHED_WAIT_BIT  = 13;
   localparam int UVP_PH_SRC_BIT     = 12;
   // Threshold scale in millivolts per step.
   localparam int UVP_THR_MV_PER_LSB = 32;
   // Overcurrent filter times and their cycle counts at 200 MHz.
   localparam int UVP_CLK_MHZ  = 200;
   localparam int UVP_FILT0_NS = 800;
   localparam int UVP_FILT1_NS = 1000;
   localparam int UVP_FILT2_NS = 1200;
   localparam logic [7:0] UVP_FILT0_CYC = 8'((UVP_FILT0_NS * UVP_CLK_MHZ + 999) / 1000);
   localparam logic [7:0] UVP_FILT1_CYC = 8'((UVP_FILT1_NS * UVP_CLK_MHZ + 999) / 1000);
   localparam logic [7:0] UVP_FILT2_CYC = 8'((UVP_FILT2_NS * UVP_CLK_MHZ + 999) / 1000);
   localparam logic [1:0] UVP_FILT_FORCE = 2'h3;
   // Phase-shedding start sequencer states.
   typedef enum logic [1:0] {UVP_SH_IDLE, UVP_SH_WAIT_VID, UVP_SH_ACTIVE} uvp_shed_t;
endpackage

// ### uvp_oc_filter.sv
// Purpose: Deglitch filter for the internal overcurrent flag.
// Assumes: The flag is synchronous to clk; the time select is a stable register field.
// Notes:   A restart on any drop of the flag gives a true minimum-high-time filter.
module uvp_oc_filter
   import uvp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       oc_raw,
   input  wire logic [1:0] time_sel,
   output logic            oc_filtered
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [7:0] limit;
   logic       done;
   logic       filt_ff;

   // Target count for the selected time.
   assign limit = (time_sel == 2'h0) ? UVP_FILT0_CYC :
                  (time_sel == 2'h1) ? UVP_FILT1_CYC : UVP_FILT2_CYC;
   assign done    = (cnt_ff >= limit);
   assign nxt_cnt = !oc_raw ? 8'h00 : (done ? cnt_ff : cnt_ff + 8'h01);

   // The count saturates at the limit so a long fault cannot wrap it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff  <= 8'h00;
         filt_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         filt_ff <= oc_raw && (nxt_cnt >= limit);
      end
   end

   // Code 11 forces the flag high regardless of the input.
   assign oc_filtered = (time_sel == UVP_FILT_FORCE) ? 1'b1 : filt_ff;

   chk_filter_min_high: assert property (@(posedge clk) disable iff (rst)
      (time_sel == 2'h0) && $rose(filt_ff) |-> $past(cnt_ff) >= (UVP_FILT0_CYC - 8'h01))
      else $error("filter released early");
endmodule // uvp_oc_filter

// ### uvp_host_model.sv
// Purpose: Host model that reaches the register bank over the decoded command port.
// Assumes: Strobes are taken on the rising edge; answers stand for one cycle.
// Notes:   Released write data and address show the inverse of the last value.
module uvp_host_model (
   input  wire logic        clk,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid,
   input  wire logic        reg_err
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle bus at time zero so nothing is taken before the first real access.
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end

   // One write: held across exactly one rising edge, then released with stale data inverted.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
      reg_addr  = ~a;
   endtask

   // One read: the answer stands in the cycle after the strobe edge, so it is sampled there.
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic e, output logic v);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      e = reg_err;
      v = reg_rvalid;
   endtask
endmodule // uvp_host_model

// ### uvp_sys_regs_test.sv
// Purpose: Self-checking bench for the protection and system setup register bank.
// Assumes: Inputs change on the falling edge; outputs are sampled there too.
// Notes:   Filter windows allow two cycles of slack around the nominal count.
module uvp_sys_regs_test
   import uvp_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst, rvalid, err, aur, oc, por, ssb, ssd, pmid, vid, th;
   logic wr, rd, e, v, atrip, acd, phr, tor, tlm, tsd, shed, uvp;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, d;
   logic [3:0] vout, rpc, apc;
   logic [5:0] csg;
   logic [9:0] thr;
   logic [2:0] sgi;
   int error_cnt = 0;
   int n_checks = 0;

   uvp_host_model i_uvp_host_model (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
      .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_err(err));
   uvp_sys_regs #(.PHASES(6)) i_uvp_sys_regs (.clk(clk), .rst(rst), .reg_addr(addr),
      .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
      .reg_err(err), .vout_mv_code(vout), .analog_uv_raw(aur), .oc_raw(oc), .por_done(por),
      .soft_start_begin(ssb), .soft_start_done(ssd), .power_state_middle(pmid),
      .vid_high_z_pin(vid),
      .cs_grounded_pin(csg), .reg_phase_count(rpc), .thermal_fault(th),
      .digital_undervolt_threshold_mv(thr), .output_undervolt_protection(uvp),
      .analog_uv_trip(atrip), .ac_droop_active(acd), .phase_half_res(phr),
      .total_half_res(tor), .sense_gain_indicator(sgi), .thermal_latch_mode(tlm),
      .thermal_shutdown(tsd), .automatic_phase_shedding(shed), .active_phase_count(apc));

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // One comparison; four-state inequality so an unknown never passes.
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
      n_checks++;
      if (s !== x) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] x);
      i_uvp_host_model.rd(a, d, e, v);
      chk({n, " data"}, d, x);
      chk({n, " ok"}, {14'h0, v, e}, (a == 8'h44 || a == 8'h45) ? 16'h0002 : 16'h0003);
   endtask

   // Reset values, read-as-zero bits and an unmapped offset.
   task automatic t_access();
      rdchk("setup rst", UVP_OFS_SYS_SETUP, 16'h0000);
      rdchk("func rst", UVP_OFS_REG_FUNC, 16'h0000);
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'hffff);
      rdchk("setup ones", UVP_OFS_SYS_SETUP, 16'hffdf);
      i_uvp_host_model.wr(UVP_OFS_REG_FUNC, 16'hffff);
      rdchk("func ones", UVP_OFS_REG_FUNC, 16'h7fff);
      i_uvp_host_model.wr(8'h46, 16'h1234);
      rdchk("unmapped", 8'h46, 16'h0000);
      chk("gain", {13'h0, sgi}, 16'h0007);
      chk("res", {14'h0, phr, tor}, 16'h0003);
      chk("latch", {15'h0, tlm}, 16'h0001);
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h5413);
      chk("gain3", {13'h0, sgi}, 16'h0003);
      chk("res2", {14'h0, phr, tor}, 16'h0002);
      chk("thr mv", {6'h0, thr}, 16'd160);
   endtask

   // Digital trip needs enable, low voltage and filtered overcurrent together.
   task automatic t_digital();
      vout = 4'h4;
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h5980);
      repeat (3) @(negedge clk);
      chk("forced trip", {15'h0, uvp}, 16'h0001);
      vout = 4'h5;
      @(negedge clk);
      chk("at threshold", {15'h0, uvp}, 16'h0000);
      vout = 4'h4;
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h5180);
      repeat (3) @(negedge clk);
      chk("disabled", {15'h0, uvp}, 16'h0000);
   endtask

   // Filter codes 00, 01 and 10 must each hold the flag back for its own count.
   task automatic t_filter();
      int n;
      int first;
      for (int c = 0; c < 3; c++) begin
         n = (c == 0) ? 160 : (c == 1) ? 200 : 240;
         first = -1;
         i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h5800 | (16'(c) << 7));
         oc = 1'b1;
         for (int i = 1; i < 260; i++) begin
            @(negedge clk);
            if (uvp === 1'b1 && first < 0) first = i;
         end
         chk("filter window", 16'(first >= n - 2 && first <= n + 2), 16'h0001);
         oc = 1'b0;
         repeat (2) @(negedge clk);
         chk("filter drop", {15'h0, uvp}, 16'h0000);
      end
   endtask

   // Analog trip: enabled, disabled, then masked by overcurrent.
   task automatic t_analog();
      aur = 1'b1;
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h0000);
      chk("ana on", {15'h0, atrip}, 16'h0001);
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h0200);
      chk("ana off", {15'h0, atrip}, 16'h0000);
      oc = 1'b1;
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h0400);
      chk("ana masked", {15'h0, atrip}, 16'h0000);
      oc = 1'b0;
      @(negedge clk);
      chk("ana unmasked", {15'h0, atrip}, 16'h0001);
      aur = 1'b0;
   endtask

   // Start sequencing: droop after power-on setup, shedding waits for the voltage-ID pin.
   task automatic t_start();
      i_uvp_host_model.wr(UVP_OFS_REG_FUNC, 16'h2000);
      chk("phase src", {12'h0, apc}, 16'h0005);
      por = 1'b1;
      repeat (3) @(negedge clk);
      chk("droop", {15'h0, acd}, 16'h0001);
      ssd = 1'b1;
      @(negedge clk);
      ssd = 1'b0;
      repeat (8) @(negedge clk);
      chk("shed wait", {15'h0, shed}, 16'h0000);
      vid = 1'b0;
      repeat (6) @(negedge clk);
      chk("shed go", {15'h0, shed}, 16'h0001);
   endtask

   // Second reset: hiccup and latch, droop at soft start, pin phase count, no vid wait.
   task automatic t_restart();
      por = 1'b0;
      vid = 1'b1;
      pmid = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("rst droop", {15'h0, acd}, 16'h0000);
      chk("rst shed", {15'h0, shed}, 16'h0000);
      th = 1'b1;
      @(negedge clk);
      chk("hiccup on", {15'h0, tsd}, 16'h0001);
      th = 1'b0;
      @(negedge clk);
      chk("hiccup off", {15'h0, tsd}, 16'h0000);
      i_uvp_host_model.wr(UVP_OFS_SYS_SETUP, 16'h0040);
      i_uvp_host_model.wr(UVP_OFS_REG_FUNC, 16'h7000);
      por = 1'b1;
      repeat (3) @(negedge clk);
      chk("droop waits", {15'h0, acd}, 16'h0000);
      chk("pin count", {12'h0, apc}, 16'h0003);
      csg = 6'h00;
      th = 1'b1;
      @(negedge clk);
      th = 1'b0;
      repeat (3) @(negedge clk);
      chk("pins ignored", {12'h0, apc}, 16'h0003);
      chk("latched", {15'h0, tsd}, 16'h0001);
      ssb = 1'b1;
      ssd = 1'b1;
      @(negedge clk);
      ssb = 1'b0;
      ssd = 1'b0;
      @(negedge clk);
      chk("droop at start", {15'h0, acd}, 16'h0001);
      chk("shed no wait", {15'h0, shed}, 16'h0001);
   endtask

   // Main sequence with every input given a value at time zero.
   initial begin
      rst = 1'b1;
      {aur, oc, por, ssb, ssd, th} = 6'h00;
      pmid = 1'b1;
      vid = 1'b1;
      vout = 4'h0;
      rpc = 4'h5;
      // Sense pins 3 and up grounded, so the pin-sensed count is three.
      csg = 6'h38;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_access();
      t_digital();
      t_filter();
      t_analog();
      t_start();
      t_restart();
      close_out();
   end
endmodule // uvp_sys_regs_test
